/* File: rtl/cscg_pkg.sv */
// package: register map, field layouts and types for the cursor, scroll and chargen control block
// Behaviour
// [R1] one 16-bit cursor register is both cursor position and memory access pointer
// [R2] after each memory access cursor steps by the two-bit direction setting
// [R3] cursor drawn in first layer for two layers, third layer for three layers
// [R4] cursor hidden when its address lies outside its layer's memory region
// [R5] dummy cursor only with graphics shown, text off, host-supplied cursor address
// [R6] auto-step is in byte units; host reloads cursor across multi-byte characters
// [R7] with no text screen shown only a bar cursor is rendered
// [R8] mixed first layer, block shape: block over text, bar over graphics
// [R9] each layer is a window split into two blocks with own start addresses
// [R10] each block's displayed start address comes from host-written scroll registers
// [R11] host blanks the newly exposed bottom line; device never clears it
// [R12] host adds or subtracts the address pitch to scroll a block
// [R13] text blocks wrap horizontally in single character steps
// [R14] three-bit pixel scroll field shifts text blocks horizontally by pixels
// [R15] host keeps pixel scroll at zero in 2 and 4 bpp modes
// [R16] text scrolls vertically by characters; graphics scrolls by pixels both ways; code forces pixel_shift to 0 in graphics mode
// [R17] pixel horizontal scroll is shared by all blocks of a screen
// [R18] pattern RAM holds 8x8 patterns at height bit 0, 8x16 at 1
// [R19] with font ROM selected pattern RAM base is relocatable anywhere
// [R20] pattern RAM use forces 1 bpp; grayscale depths not allowed
// [R21] font ROM gives 160 chars of 5x7, mixable with 64 pattern RAM chars
// [R22] host saves and restores cursor around accesses outside the visible area
// [R23] graphics mode line start is previous line start plus address pitch
// [R24] pattern fetch address is base plus shifted code plus row index
// [R25] cursor stepping wraps modulo 65536 without any error indication
package cscg_pkg;
    localparam int ADDR_W = 16;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PITCH  = 8'h06;
    localparam logic [7:0] OFS_SAD1   = 8'h0b;
    localparam logic [7:0] OFS_SAD2   = 8'h0e;
    localparam logic [7:0] OFS_SAD3   = 8'h11;
    localparam logic [7:0] OFS_SAD4   = 8'h14;
    localparam logic [7:0] OFS_DIR    = 8'h17;
    localparam logic [7:0] OFS_OVLAY  = 8'h18;
    localparam logic [7:0] OFS_PTBASE = 8'h19;
    localparam logic [7:0] OFS_HSCR   = 8'h1b;
    localparam logic [7:0] OFS_CURSOR = 8'h1c;
    localparam logic [7:0] OFS_DISP   = 8'h20;
    localparam logic [7:0] OFS_MEMACC = 8'h21;
    localparam logic [7:0] OFS_STATUS = 8'h22;
    localparam logic [7:0] OFS_LIMIT1 = 8'h23;
    localparam logic [7:0] OFS_LIMIT3 = 8'h24;
    localparam logic [7:0] OFS_FETCH  = 8'h25;
    localparam int CTRL_CGSEL_BIT  = 0;
    localparam int CTRL_TALL_BIT   = 2;
    localparam int OVLAY_THREE_BIT = 4;
    localparam int DISP_TEXT_BIT   = 0;
    localparam int DISP_GFX_BIT    = 1;
    localparam int DISP_BLOCK_BIT  = 2;
    localparam int DISP_MIXED_BIT  = 3;
    localparam int DISP_HOSTC_BIT  = 4;
    localparam int DISP_BPP_LSB    = 5;
    localparam int DISP_GFXMODE_BIT = 7;
    localparam int FONT_ROM_CHARS  = 160;
    localparam int PATTERN_CHARS   = 64;
    localparam logic [1:0] BPP_ONE = 2'h0;
    localparam logic [15:0] RST_PITCH = 16'h0028;
    localparam logic [15:0] RST_LIMIT = 16'hffff;
    localparam logic [7:0]  RST_DIR   = 8'h00;

    typedef enum logic [1:0] {
        CSCG_DIR_RIGHT = 2'b00,
        CSCG_DIR_LEFT  = 2'b01,
        CSCG_DIR_UP    = 2'b10,
        CSCG_DIR_DOWN  = 2'b11
    } cscg_dir_type;

    typedef enum logic [1:0] {
        CSCG_SHAPE_NONE  = 2'b00,
        CSCG_SHAPE_BAR   = 2'b01,
        CSCG_SHAPE_BLOCK = 2'b10
    } cscg_shape_type;

    typedef enum logic [1:0] {
        CSCG_LAYER_FIRST = 2'b01,
        CSCG_LAYER_THIRD = 2'b11
    } cscg_layer_type;

    typedef struct packed {
        logic            visible;
        cscg_shape_type  shape;
        cscg_layer_type  layer;
        logic [15:0]     addr;
    } cscg_cursor_type;

    typedef struct packed {
        logic [15:0] line_start;
        logic [15:0] pattern_addr;
        logic [2:0]  pixel_shift;
    } cscg_scan_type;
endpackage

/* File: rtl/cscg_ctrl.sv */
// cursor, scroll and character generator control with a classic wishbone register slave
module cscg_ctrl
    import cscg_pkg::*;
#(
    parameter int NUM_BLOCKS = 4
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    output logic                      wb_ack_o,
    input  wire logic                 line_start_i,
    input  wire logic                 frame_start_i,
    input  wire logic [1:0]           scan_block_i,
    input  wire logic                 scan_text_i,
    input  wire logic [7:0]           char_code_i,
    input  wire logic [3:0]           char_row_i,
    output cscg_cursor_type           cursor_o,
    output cscg_scan_type             scan_o,
    output logic [7:0]                mem_data_o,
    output logic                      mem_we_o,
    output logic [15:0]               mem_addr_o,
    output logic                      rom_sel_o,
    output logic                      cfg_error_o
);

    if (NUM_BLOCKS != 4) begin : g_param_check
        $error("cscg_ctrl: NUM_BLOCKS must be 4");
    end

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [7:0]  ctrl_reg;
    logic [15:0] pitch;
    logic [15:0] block_start_address [NUM_BLOCKS];
    logic [7:0]  cursor_step_direction_cmd;
    logic [7:0]  overlay;
    logic [15:0] pattern_table_base;
    logic [2:0]  pixel_hscroll_field;
    logic [15:0] cursor_addr;
    logic [7:0]  disp;
    logic [15:0] limit_first;
    logic [15:0] limit_third;
    logic [15:0] line_start;

    logic bus_req;
    logic wr_en;
    logic rd_en;
    logic mem_access;
    assign bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en      = bus_req && wb_we_i;
    assign rd_en      = bus_req && !wb_we_i;
    assign mem_access = bus_req && (wb_adr_i == OFS_MEMACC);

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        return adr == ofs;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) r[7:0] = d[7:0];
        if (sel[1]) r[15:8] = d[15:8];
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // wishbone ack: one cycle after request

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg                  <= 8'h00;
            pitch                     <= RST_PITCH;
            cursor_step_direction_cmd <= RST_DIR;
            overlay                   <= 8'h00;
            pattern_table_base        <= 16'h0000;
            pixel_hscroll_field       <= 3'h0;
            disp                      <= 8'h00;
            limit_first               <= RST_LIMIT;
            limit_third               <= RST_LIMIT;
        end else if (wr_en && wb_sel_i[0]) begin
            if (hit(wb_adr_i, OFS_CTRL)) ctrl_reg <= wb_dat_i[7:0];
            else if (hit(wb_adr_i, OFS_PITCH)) pitch <= merge16(pitch, wb_dat_i, wb_sel_i);
            else if (hit(wb_adr_i, OFS_DIR)) cursor_step_direction_cmd <= wb_dat_i[7:0];
            else if (hit(wb_adr_i, OFS_OVLAY)) overlay <= wb_dat_i[7:0];
            else if (hit(wb_adr_i, OFS_PTBASE)) pattern_table_base <= merge16(pattern_table_base, wb_dat_i, wb_sel_i); // R19
            else if (hit(wb_adr_i, OFS_HSCR)) pixel_hscroll_field <= wb_dat_i[2:0]; // R14 R17
            else if (hit(wb_adr_i, OFS_DISP)) disp <= wb_dat_i[7:0];
            else if (hit(wb_adr_i, OFS_LIMIT1)) limit_first <= merge16(limit_first, wb_dat_i, wb_sel_i);
            else if (hit(wb_adr_i, OFS_LIMIT3)) limit_third <= merge16(limit_third, wb_dat_i, wb_sel_i);
        end
    end

    // scroll start registers, one per block
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_sad
            localparam logic [7:0] OFS = OFS_SAD1 + 8'(3 * gi);
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    block_start_address[gi] <= 16'h0000;
                end else if (wr_en && wb_sel_i[0] && hit(wb_adr_i, OFS)) begin
                    block_start_address[gi] <= merge16(block_start_address[gi], wb_dat_i, wb_sel_i); // R9 R10
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // cursor pointer and memory access port

    logic [15:0] step;
    always_comb begin
        case (cscg_dir_type'(cursor_step_direction_cmd[1:0]))
            CSCG_DIR_RIGHT: step = 16'h0001;
            CSCG_DIR_LEFT:  step = 16'hffff;
            CSCG_DIR_UP:    step = 16'(-pitch);
            default:        step = pitch;
        endcase
    end

    logic [15:0] next_cursor;
    assign next_cursor = cursor_addr + step; // R2 R6 R25

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cursor_addr <= 16'h0000;
        end else if (wr_en && hit(wb_adr_i, OFS_CURSOR) && wb_sel_i[0]) begin
            cursor_addr <= merge16(cursor_addr, wb_dat_i, wb_sel_i); // R1
        end else if (mem_access) begin
            cursor_addr <= next_cursor; // R2
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_we_o   <= 1'b0;
            mem_addr_o <= 16'h0000;
            mem_data_o <= 8'h00;
        end else begin
            mem_we_o <= mem_access && wb_we_i && wb_sel_i[0];
            if (mem_access) begin
                mem_addr_o <= cursor_addr; // R1
                mem_data_o <= wb_dat_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cursor layer, visibility and shape

    logic three_layers;
    logic text_on;
    logic gfx_on;
    logic host_cursor;
    logic in_region;
    logic [15:0] layer_base;
    logic [15:0] layer_limit;
    cscg_shape_type next_shape;

    assign three_layers = overlay[OVLAY_THREE_BIT];
    assign text_on      = disp[DISP_TEXT_BIT];
    assign gfx_on       = disp[DISP_GFX_BIT];
    assign host_cursor  = disp[DISP_HOSTC_BIT];
    assign layer_base   = three_layers ? block_start_address[3] : block_start_address[0]; // R3
    assign layer_limit  = three_layers ? limit_third : limit_first;
    assign in_region    = (cursor_addr >= layer_base) && (cursor_addr <= layer_limit); // R4

    always_comb begin
        next_shape = CSCG_SHAPE_NONE;
        if (!in_region) begin
            next_shape = CSCG_SHAPE_NONE; // R4
        end else if (!text_on) begin
            if (gfx_on && host_cursor) next_shape = CSCG_SHAPE_BAR; // R5 R7
        end else if (disp[DISP_BLOCK_BIT]) begin
            if (disp[DISP_MIXED_BIT] && !scan_text_i) next_shape = CSCG_SHAPE_BAR; // R8
            else next_shape = CSCG_SHAPE_BLOCK; // R8
        end else begin
            next_shape = CSCG_SHAPE_BAR;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cursor_o <= '0;
        end else begin
            cursor_o.visible <= next_shape != CSCG_SHAPE_NONE;
            cursor_o.shape   <= next_shape;
            cursor_o.layer   <= three_layers ? CSCG_LAYER_THIRD : CSCG_LAYER_FIRST; // R3
            cursor_o.addr    <= cursor_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scan line start and pattern fetch address

    logic gfx_mode;
    assign gfx_mode = disp[DISP_GFXMODE_BIT];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            line_start <= 16'h0000;
        end else if (frame_start_i) begin
            line_start <= block_start_address[scan_block_i]; // R10
        end else if (line_start_i && (gfx_mode || char_row_i == 4'h0)) begin
            line_start <= line_start + pitch; // R16 R23
        end
    end

    logic [15:0] code_shifted;
    logic [15:0] row_index;
    assign code_shifted = ctrl_reg[CTRL_TALL_BIT] ? {4'h0, char_code_i, 4'h0}
                                                  : {5'h00, char_code_i, 3'h0}; // R18
    assign row_index    = ctrl_reg[CTRL_TALL_BIT] ? {12'h000, char_row_i} : {13'h0000, char_row_i[2:0]};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scan_o <= '0;
        end else begin
            scan_o.line_start   <= line_start;
            scan_o.pattern_addr <= pattern_table_base + code_shifted + row_index; // R24
            scan_o.pixel_shift  <= gfx_mode ? 3'h0 : pixel_hscroll_field; // R13 R14 R17
        end
    end

    // with ctrl bit 0 clear font ROM covers the non-pattern codes; pattern RAM codes, and all codes with it set, go to memory
    logic pattern_code;
    assign pattern_code = (char_code_i[7:5] == 3'b100) || (char_code_i[7:5] == 3'b111); // R21

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rom_sel_o   <= 1'b0;
            cfg_error_o <= 1'b0;
        end else begin
            rom_sel_o   <= !ctrl_reg[CTRL_CGSEL_BIT] && !pattern_code; // R19 R21
            cfg_error_o <= disp[DISP_BPP_LSB +: 2] != BPP_ONE; // R15 R20
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_en) begin
            if (hit(wb_adr_i, OFS_CTRL)) wb_dat_o <= {24'h000000, ctrl_reg};
            else if (hit(wb_adr_i, OFS_PITCH)) wb_dat_o <= {16'h0000, pitch};
            else if (hit(wb_adr_i, OFS_SAD1)) wb_dat_o <= {16'h0000, block_start_address[0]};
            else if (hit(wb_adr_i, OFS_SAD2)) wb_dat_o <= {16'h0000, block_start_address[1]};
            else if (hit(wb_adr_i, OFS_SAD3)) wb_dat_o <= {16'h0000, block_start_address[2]};
            else if (hit(wb_adr_i, OFS_SAD4)) wb_dat_o <= {16'h0000, block_start_address[3]};
            else if (hit(wb_adr_i, OFS_DIR)) wb_dat_o <= {24'h000000, cursor_step_direction_cmd};
            else if (hit(wb_adr_i, OFS_OVLAY)) wb_dat_o <= {24'h000000, overlay};
            else if (hit(wb_adr_i, OFS_PTBASE)) wb_dat_o <= {16'h0000, pattern_table_base};
            else if (hit(wb_adr_i, OFS_HSCR)) wb_dat_o <= {29'h00000000, pixel_hscroll_field};
            else if (hit(wb_adr_i, OFS_CURSOR)) wb_dat_o <= {16'h0000, cursor_addr};
            else if (hit(wb_adr_i, OFS_DISP)) wb_dat_o <= {24'h000000, disp};
            else if (hit(wb_adr_i, OFS_STATUS)) wb_dat_o <= {28'h0000000, cfg_error_o, in_region,
                                                          three_layers, text_on};
            else if (hit(wb_adr_i, OFS_LIMIT1)) wb_dat_o <= {16'h0000, limit_first};
            else if (hit(wb_adr_i, OFS_LIMIT3)) wb_dat_o <= {16'h0000, limit_third};
            else if (hit(wb_adr_i, OFS_FETCH)) wb_dat_o <= {16'h0000, scan_o.pattern_addr};
            else wb_dat_o <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    AST_ACK_ONE: assert property (@(posedge clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o) else $error("ack held more than one cycle");
    AST_STEP: assert property (@(posedge clk) disable iff (reset) // R2
        (mem_access && !wr_en) || (mem_access && wr_en) |=> cursor_addr == $past(next_cursor))
        else $error("cursor did not step after memory access");
    AST_WRAP: assert property (@(posedge clk) disable iff (reset) // R25
        mem_access && cursor_addr == 16'hffff && cursor_step_direction_cmd[1:0] == 2'b00
        |=> cursor_addr == 16'h0000) else $error("cursor did not wrap");
    AST_MEMADDR: assert property (@(posedge clk) disable iff (reset) // R1
        mem_access |=> mem_addr_o == $past(cursor_addr)) else $error("memory pointer mismatch");
    AST_LAYER: assert property (@(posedge clk) disable iff (reset) // R3
        !$past(reset) |-> cursor_o.layer == ($past(three_layers) ? CSCG_LAYER_THIRD : CSCG_LAYER_FIRST))
        else $error("cursor layer wrong");
    AST_HIDE: assert property (@(posedge clk) disable iff (reset) // R4
        !in_region |=> !cursor_o.visible) else $error("cursor shown outside its layer");
    AST_BAR_ONLY: assert property (@(posedge clk) disable iff (reset) // R7
        !text_on |=> cursor_o.shape != CSCG_SHAPE_BLOCK) else $error("block cursor without text");
    AST_DUMMY: assert property (@(posedge clk) disable iff (reset) // R5
        !text_on && !(gfx_on && host_cursor) |=> !cursor_o.visible) else $error("dummy cursor shown");
    AST_MIXED: assert property (@(posedge clk) disable iff (reset) // R8
        in_region && text_on && disp[DISP_BLOCK_BIT] && disp[DISP_MIXED_BIT] && !scan_text_i
        |=> cursor_o.shape == CSCG_SHAPE_BAR) else $error("mixed layer shape wrong");
    AST_LINE: assert property (@(posedge clk) disable iff (reset) // R23
        line_start_i && !frame_start_i && gfx_mode |=> line_start == $past(line_start) + $past(pitch))
        else $error("line start not advanced by pitch");
    AST_PATTERN: assert property (@(posedge clk) disable iff (reset) // R24
        ##1 scan_o.pattern_addr == $past(pattern_table_base) + $past(code_shifted) + $past(row_index))
        else $error("pattern address wrong");

endmodule

/* File: test/cscg_host.sv */
// host model: classic wishbone master issuing register and memory accesses
module cscg_host (
    input  wire logic        clk,
    output logic [7:0]       adr,
    output logic [31:0]      dat,
    output logic             we,
    output logic [3:0]       sel,
    output logic             cyc,
    output logic             stb,
    input  wire logic        ack,
    input  wire logic [31:0] rdat
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        adr = 8'h00;
        dat = 32'h0;
        we  = 1'b0;
        sel = 4'h0;
        cyc = 1'b0;
        stb = 1'b0;
    end

    // request held until the edge that samples ack, then released for a cycle
    task automatic access(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [3:0] s,
                          output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        dat <= d;
        we  <= w;
        sel <= s;
        cyc <= 1'b1;
        stb <= 1'b1;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] q;
        access(a, d, 1'b1, s, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        access(a, 32'h0, 1'b0, 4'hf, q);
    endtask
endmodule

/* File: test/cscg_ctrl_bench.sv */
// bench: register, cursor stepping, scroll and pattern fetch checks
module cscg_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cscg_pkg::*;

    logic clk, reset, line_start_i, frame_start_i, scan_text_i;
    logic [1:0] scan_block_i;
    logic [7:0] char_code_i, adr, mem_data_o, last_data;
    logic [3:0] char_row_i, sel;
    logic [31:0] dat, rdat, q;
    logic we, cyc, stb, ack, mem_we_o, rom_sel_o, cfg_error_o;
    logic [15:0] mem_addr_o, last_addr, s, e;
    cscg_cursor_type cursor_o;
    cscg_scan_type scan_o;
    int bad_count, n_compared, we_seen;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    cscg_host u_host (.clk(clk), .adr(adr), .dat(dat), .we(we), .sel(sel), .cyc(cyc), .stb(stb),
                      .ack(ack), .rdat(rdat));

    cscg_ctrl #(.NUM_BLOCKS(4)) u_dut (.clk(clk), .reset(reset), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .line_start_i(line_start_i), .frame_start_i(frame_start_i), .scan_block_i(scan_block_i),
        .scan_text_i(scan_text_i), .char_code_i(char_code_i), .char_row_i(char_row_i),
        .cursor_o(cursor_o), .scan_o(scan_o), .mem_data_o(mem_data_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .rom_sel_o(rom_sel_o), .cfg_error_o(cfg_error_o));

    // memory write monitor
    always @(posedge clk) begin
        if (mem_we_o === 1'b1) begin
            last_addr <= mem_addr_o;
            last_data <= mem_data_o;
            we_seen   <= we_seen + 1;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
        u_host.rd(a, q);
        check(q, exp, what);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic scan_pulse(input logic frame, input logic [1:0] blk);
        @(posedge clk);
        scan_block_i <= blk;
        frame_start_i <= frame;
        line_start_i <= ~frame;
        @(posedge clk);
        frame_start_i <= 1'b0;
        line_start_i <= 1'b0;
        settle();
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        reset = 1'b1;
        {line_start_i, frame_start_i, scan_text_i, scan_block_i, char_code_i, char_row_i} = '0;
        bad_count = 0;
        n_compared = 0;
        we_seen = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd_check(OFS_PITCH, 32'h0028, "pitch reset");
        rd_check(OFS_LIMIT3, 32'hffff, "limit reset");
        rd_check(OFS_DIR, 32'h0, "dir reset");
        rd_check(8'h30, 32'h0, "unmapped");
        for (int d = 0; d < 4; d++) begin
            s = (d == 0) ? 16'hffff : (d == 1) ? 16'h0000 : (d == 2) ? 16'h0010 : 16'hffe0;
            e = (d == 0) ? s + 16'h1 : (d == 1) ? s - 16'h1 : (d == 2) ? s - 16'h0028 : s + 16'h0028;
            u_host.wr(OFS_DIR, 32'(d));
            u_host.wr(OFS_CURSOR, {16'h0, s});
            u_host.wr(OFS_MEMACC, 32'(8'ha0 + d));
            settle();
            check(32'(last_addr), 32'(s), "access address");
            check(32'(last_data), 32'(8'ha0 + d), "write data");
            rd_check(OFS_CURSOR, 32'(e), "stepped cursor");
        end
        u_host.wr(OFS_DIR, 32'h0);
        u_host.wr(OFS_CURSOR, 32'h0100);
        u_host.wr(OFS_MEMACC, 32'h11);
        u_host.wr(OFS_MEMACC, 32'h22);
        u_host.rd(OFS_MEMACC, q);
        u_host.wr(OFS_CURSOR, 32'h5555, 4'h2);
        settle();
        check(32'(we_seen), 32'd6, "write pulses");
        rd_check(OFS_CURSOR, 32'h0103, "byte steps");
        u_host.wr(OFS_OVLAY, 32'h0);
        settle();
        check(32'(cursor_o.layer), 32'(CSCG_LAYER_FIRST), "two layers");
        u_host.wr(OFS_OVLAY, 32'h10);
        settle();
        check(32'(cursor_o.layer), 32'(CSCG_LAYER_THIRD), "three layers");
        u_host.wr(OFS_OVLAY, 32'h0);
        u_host.wr(OFS_DISP, 32'h01);
        u_host.wr(OFS_SAD1, 32'h1000);
        u_host.wr(OFS_LIMIT1, 32'h10ff);
        u_host.wr(OFS_CURSOR, 32'h10ff);
        settle();
        check({15'h0, cursor_o.visible, cursor_o.addr}, 32'h110ff, "inside region");
        u_host.wr(OFS_CURSOR, 32'h1100);
        settle();
        check(32'(cursor_o.visible), 32'h0, "above region");
        u_host.wr(OFS_CURSOR, 32'h0fff);
        settle();
        check(32'(cursor_o.visible), 32'h0, "below region");
        u_host.wr(OFS_CURSOR, 32'h1000);
        u_host.wr(OFS_DISP, 32'h16);
        settle();
        check({29'h0, cursor_o.visible, cursor_o.shape}, {29'h0, 1'b1, CSCG_SHAPE_BAR}, "dummy bar");
        u_host.wr(OFS_DISP, 32'h06);
        settle();
        check(32'(cursor_o.visible), 32'h0, "no host cursor");
        u_host.wr(OFS_DISP, 32'h0f);
        scan_text_i <= 1'b1;
        settle();
        check(32'(cursor_o.shape), 32'(CSCG_SHAPE_BLOCK), "mixed text");
        @(posedge clk);
        scan_text_i <= 1'b0;
        settle();
        check(32'(cursor_o.shape), 32'(CSCG_SHAPE_BAR), "mixed gfx");
        u_host.wr(OFS_HSCR, 32'h5);
        u_host.wr(OFS_DISP, 32'h82);
        u_host.wr(OFS_SAD1, 32'h0200 + 32'h0028);
        u_host.wr(OFS_CURSOR, 32'h0250);
        u_host.wr(OFS_MEMACC, 32'h0);
        scan_pulse(1'b1, 2'd0);
        check(32'(scan_o.line_start), 32'h0228, "block start");
        check(32'(scan_o.pixel_shift), 32'h0, "gfx no shift");
        check(32'(last_addr), 32'h0250, "blanked line");
        scan_pulse(1'b0, 2'd0);
        check(32'(scan_o.line_start), 32'h0250, "next line");
        u_host.wr(OFS_SAD4, 32'h3000);
        scan_pulse(1'b1, 2'd3);
        check(32'(scan_o.line_start), 32'h3000, "fourth block");
        u_host.wr(OFS_DISP, 32'h01);
        u_host.wr(OFS_SAD2, 32'h0800);
        scan_pulse(1'b1, 2'd1);
        check({13'h0, scan_o.pixel_shift, scan_o.line_start}, {13'h0, 3'h5, 16'h0800}, "shared shift");
        u_host.wr(OFS_PTBASE, 32'h4800);
        u_host.wr(OFS_CTRL, 32'h0);
        char_code_i <= 8'h80;
        char_row_i <= 4'h3;
        settle();
        check({15'h0, rom_sel_o, scan_o.pattern_addr}, 32'h4c03, "short fetch");
        u_host.wr(OFS_CTRL, 32'h04);
        char_code_i <= 8'he0;
        char_row_i <= 4'hf;
        settle();
        check(32'(scan_o.pattern_addr), 32'h560f, "tall fetch");
        rd_check(OFS_FETCH, 32'h560f, "fetch readback");
        @(posedge clk);
        char_code_i <= 8'h41;
        settle();
        check(32'(rom_sel_o), 32'h1, "rom code");
        u_host.wr(OFS_CTRL, 32'h01);
        settle();
        check(32'(rom_sel_o), 32'h0, "ram only");
        u_host.wr(OFS_HSCR, 32'h0);
        u_host.wr(OFS_DISP, 32'h21);
        settle();
        check(32'(cfg_error_o), 32'h1, "grayscale");
        check(32'(scan_o.pixel_shift), 32'h0, "gray no shift");
        rd_check(OFS_STATUS, 32'hd, "status");
        u_host.wr(OFS_DISP, 32'h01);
        settle();
        check(32'(cfg_error_o), 32'h0, "one bpp");
        u_host.rd(OFS_CURSOR, q);
        s = q[15:0];
        u_host.wr(OFS_CURSOR, 32'hf000);
        u_host.wr(OFS_MEMACC, 32'h5a);
        u_host.wr(OFS_CURSOR, {16'h0, s});
        settle();
        check(32'(last_addr), 32'hf000, "outside access");
        rd_check(OFS_CURSOR, {16'h0, s}, "cursor restored");
        end_of_test();
    end
endmodule
